// *** rtl/stx_defines.svh ***
/*
 Constants for the serial audio input stage: word width codes, word widths,
 right-justified MSB offsets and frame length.
 Assumes inclusion by bare name from the design file.
*/
`ifndef STX_DEFINES_SVH
`define STX_DEFINES_SVH
// Word width codes
`define STX_W16 2'h0
`define STX_W18 2'h1
`define STX_W20 2'h2
`define STX_W24 2'h3
// Bits per word
`define STX_BITS16 5'h10
`define STX_BITS18 5'h12
`define STX_BITS20 5'h14
`define STX_BITS24 5'h18
// Right-justified delay from frame sync edge to MSB, in serial clocks
`define STX_RJ16 6'h10
`define STX_RJ18 6'h0E
`define STX_RJ20 6'h0C
`define STX_RJ24 6'h08
// I2S delay from frame sync edge to MSB
`define STX_I2S_DLY 6'h01
// Serial clocks per frame sync period assumed for right-justified
`define STX_FRAME_SCLK 7'h40
// Data FIFO depth
`define STX_FIFO_DEPTH 32
`endif

// *** rtl/stx_pkg.sv ***
/*
 Types of the serial audio input stage.
 Assumes stx_defines.svh is on the include path.
*/
package stx_pkg;
   // Framing; I2S is the default
   typedef enum logic [1:0] {
      STX_FMT_I2S,
      STX_FMT_LJ,
      STX_FMT_RJ
   } stx_fmt_e;
   typedef logic [1:0] stx_width_t;
endpackage

// *** rtl/stx_serial_in.sv ***
/*
 Serial audio input stage: samples bit clock, frame sync and data on the
 core clock, deserializes stereo words and queues them in a FIFO.
 Assumes the serial clock is at most a quarter of core_clk, and that the
 encoder downstream drains words via valid/ready.
*/
// Notes on behaviour
// - Left-justified, I2S and right-justified framing are selected by the format input.
// - Word width is 16, 18, 20 or 24 bits and exactly that many bits are assembled per slot.
// - In right-justified framing a high frame sync is the left slot and low the right slot.
// - Data and frame sync are sampled on the rising serial clock edge in every framing.
// - In right-justified framing the MSB follows the sync edge after 16, 14, 12 or 8 clocks.
// - Right-justified placement assumes 64 clocks per frame so the LSB ends at the next sync edge.
// - I2S is the default framing and in it a low sync is the left slot and high the right slot.
// - In I2S framing the MSB arrives one serial clock after the sync edge.
// - In left-justified framing a high sync is the left slot and low the right slot.
// - In left-justified framing the MSB is taken on the rising edge that carries the sync edge.

`include "stx_defines.svh"

// Word FIFO in flip-flops
module stx_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = 32
) (
   input wire logic core_clk, // Core clock
   input wire logic sys_rst, // Async reset, high
   input wire logic in_valid, // Write request
   output logic in_ready, // Not full
   input wire logic [WIDTH-1:0] in_data, // Write data
   output logic out_valid, // Not empty
   input wire logic out_ready, // Read accept
   output logic [WIDTH-1:0] out_data // Read data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   // Pointers and fill count
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   // Storage
   always_ff @(posedge core_clk) begin
      if (push) mem[wr_ptr] <= in_data;
   end

   // Fill bound and hold of full and empty
   chk_fifo_bound: assert property (@(posedge core_clk) disable iff (sys_rst)
      count <= (AW+1)'(DEPTH))
      else $error("FIFO fill count above depth");
   chk_fifo_full: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!in_ready && !out_ready) |=> !in_ready)
      else $error("FIFO full flag dropped without a read");
   chk_fifo_empty: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!out_valid && !in_valid) |=> !out_valid)
      else $error("FIFO valid raised without a write");
endmodule

module stx_serial_in
   import stx_pkg::*;
#(
   parameter int DEPTH = `STX_FIFO_DEPTH
) (
   input wire logic core_clk, // 50 MHz core clock
   input wire logic sys_rst, // Async reset, high
   input wire logic sclk, // Serial bit clock pin
   input wire logic fsync, // Frame sync pin
   input wire logic sdata, // Serial data pin
   input wire stx_pkg::stx_fmt_e fmt, // Framing select
   input wire stx_pkg::stx_width_t width, // Word width select
   output logic word_valid, // Word available
   input wire logic word_ready, // Encoder takes word
   output logic [23:0] word_data, // Sample, MSB aligned at bit 23
   output logic word_right, // High for right channel
   output logic overflow // Sticky: word lost, FIFO full
);
   import stx_pkg::*;

   // Synchroniser stages
   logic [2:0] sclk_s;
   logic [1:0] fs_s;
   logic [1:0] sd_s;

   // Slot tracking and shifter
   logic fs_prev;
   logic [6:0] bit_cnt;
   logic [23:0] shreg;
   logic [4:0] got;
   logic slot_right;
   logic capturing;

   // FIFO write side and overflow
   logic wr_valid;
   logic [24:0] wr_data;
   logic ff_out_valid;
   logic [24:0] ff_out_data;
   logic ff_in_ready;
   logic out_full;

   // Pin synchronisers; sclk gets a third stage for edge detection
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclk_s <= 3'h0;
         fs_s <= 2'h0;
         sd_s <= 2'h0;
      end else begin
         sclk_s <= {sclk_s[1:0], sclk};
         fs_s <= {fs_s[0], fsync};
         sd_s <= {sd_s[0], sdata};
      end
   end

   // Rising serial clock edge seen after two stages
   wire rise = sclk_s[1] && !sclk_s[2];
   wire fs_now = fs_s[1];
   wire fs_edge = rise && (fs_now != fs_prev);

   // Word length and MSB offset from sync edge per format
   wire [4:0] nbits = (width == `STX_W16) ? `STX_BITS16 :
                      (width == `STX_W18) ? `STX_BITS18 :
                      (width == `STX_W20) ? `STX_BITS20 : `STX_BITS24;
   wire [6:0] rj_dly = {1'b0, (width == `STX_W16) ? `STX_RJ16 :
                               (width == `STX_W18) ? `STX_RJ18 :
                               (width == `STX_W20) ? `STX_RJ20 : `STX_RJ24};
   wire [6:0] msb_pos = (fmt == STX_FMT_RJ) ? rj_dly :
                        (fmt == STX_FMT_I2S) ? {1'b0, `STX_I2S_DLY} : 7'h00;
   // Slot polarity: I2S low=left, LJ/RJ high=left
   wire next_right = (fmt == STX_FMT_I2S) ? fs_now : !fs_now;
   // Bit index within slot for this rising edge (0 on the sync edge)
   wire [6:0] idx = fs_edge ? 7'h00 : bit_cnt;
   wire start_bit = (idx == msb_pos);
   wire last_bit = capturing && (got == nbits - 5'h01);
   // Shifter value after this edge's bit is taken
   wire [23:0] shifted = {shreg[22:0], sd_s[1]};

   // Slot counter and shifter, all on rising serial clock edges
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fs_prev <= 1'b0;
         bit_cnt <= 7'h7F;
         shreg <= 24'h0;
         got <= 5'h0;
         slot_right <= 1'b0;
         capturing <= 1'b0;
      end else if (rise) begin
         fs_prev <= fs_now;
         bit_cnt <= (idx == 7'h7F) ? idx : idx + 7'h01;
         if (fs_edge) slot_right <= next_right;
         if (start_bit) begin
            shreg <= {23'h0, sd_s[1]};
            got <= 5'h1;
            capturing <= (nbits != 5'h01);
         end else if (capturing) begin
            shreg <= shifted;
            got <= got + 5'h01;
            if (last_bit) capturing <= 1'b0;
         end
      end
   end

   // Finished word goes to the FIFO as one write
   wire done = rise && capturing && !start_bit && last_bit;
   wire [4:0] sh_amt = 5'h18 - nbits; // Left-aligns the word to 24 bits
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_valid <= 1'b0;
         wr_data <= 25'h0;
         out_full <= 1'b0;
      end else begin
         wr_valid <= done;
         if (done) wr_data <= {(fs_edge ? !next_right : slot_right), shifted << sh_amt};
         if (wr_valid && !ff_in_ready) out_full <= 1'b1;
      end
   end

   // FIFO is read whenever the output register is empty or being taken
   wire pop_ok = !word_valid || word_ready;
   stx_fifo #(.WIDTH(25), .DEPTH(DEPTH)) stx_fifo_i (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .in_valid(wr_valid),
      .in_ready(ff_in_ready),
      .in_data(wr_data),
      .out_valid(ff_out_valid),
      .out_ready(pop_ok),
      .out_data(ff_out_data)
   );

   // Output stage register
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         word_valid <= 1'b0;
         word_data <= 24'h0;
         word_right <= 1'b0;
         overflow <= 1'b0;
      end else begin
         overflow <= out_full;
         if (pop_ok) begin
            word_valid <= ff_out_valid;
            if (ff_out_valid) begin
               word_data <= ff_out_data[23:0];
               word_right <= ff_out_data[24];
            end
         end
      end
   end

   // Assertions
   chk_word_single: assert property (@(posedge core_clk) disable iff (sys_rst)
      wr_valid |=> !wr_valid)
      else $error("word written twice");
   chk_start_i2s: assert property (@(posedge core_clk) disable iff (sys_rst)
      (rise && fmt == STX_FMT_I2S && idx == 7'h01) |=> (got == 5'h01 && shreg[0] == $past(sd_s[1])))
      else $error("I2S MSB not taken one clock after sync edge");
   chk_start_lj: assert property (@(posedge core_clk) disable iff (sys_rst)
      (fs_edge && fmt == STX_FMT_LJ) |=> (got == 5'h01 && shreg[0] == $past(sd_s[1])))
      else $error("LJ MSB not on sync edge");
   chk_rj_offset: assert property (@(posedge core_clk) disable iff (sys_rst)
      (rise && fmt == STX_FMT_RJ && width == `STX_W24 && idx == 7'h08) |-> start_bit)
      else $error("RJ 24 bit MSB offset wrong");
   chk_slot_i2s: assert property (@(posedge core_clk) disable iff (sys_rst)
      (fs_edge && fmt == STX_FMT_I2S) |=> (slot_right == $past(fs_now)))
      else $error("I2S channel polarity wrong");
   chk_slot_lj: assert property (@(posedge core_clk) disable iff (sys_rst)
      (fs_edge && fmt == STX_FMT_LJ) |=> (slot_right == !$past(fs_now)))
      else $error("LJ channel polarity wrong");
   chk_slot_rj: assert property (@(posedge core_clk) disable iff (sys_rst)
      (fs_edge && fmt == STX_FMT_RJ) |=> (slot_right == !$past(fs_now)))
      else $error("RJ channel polarity wrong");
   chk_bit_count: assert property (@(posedge core_clk) disable iff (sys_rst)
      done |-> (got == nbits - 5'h01))
      else $error("word length wrong");
   chk_sample_edge: assert property (@(posedge core_clk) disable iff (sys_rst)
      (rise && (start_bit || capturing)) |=> (shreg[0] == $past(sd_s[1])))
      else $error("sampled off rising edge");
   chk_rj_end: assert property (@(posedge core_clk) disable iff (sys_rst)
      (rise && fmt == STX_FMT_RJ && start_bit) |-> (msb_pos + {2'h0, nbits} == 7'(`STX_FRAME_SCLK / 2)))
      else $error("RJ word not ending at sync edge");

   // Right-justified offsets for the remaining widths
   chk_rj_off16: assert property (@(posedge core_clk) disable iff (sys_rst)
      (rise && fmt == STX_FMT_RJ && width == `STX_W16 && idx == 7'h10) |=> (got == 5'h01))
      else $error("RJ 16 bit MSB offset wrong");
   chk_rj_off18: assert property (@(posedge core_clk) disable iff (sys_rst)
      (rise && fmt == STX_FMT_RJ && width == `STX_W18 && idx == 7'h0E) |=> (got == 5'h01))
      else $error("RJ 18 bit MSB offset wrong");
   chk_rj_off20: assert property (@(posedge core_clk) disable iff (sys_rst)
      (rise && fmt == STX_FMT_RJ && width == `STX_W20 && idx == 7'h0C) |=> (got == 5'h01))
      else $error("RJ 20 bit MSB offset wrong");
   chk_rj_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
      (rise && fmt == STX_FMT_RJ && idx < msb_pos) |=> !capturing)
      else $error("RJ bit taken before MSB slot");

   // Short words leave with zeroed low bits
   chk_lsb_w16: assert property (@(posedge core_clk) disable iff (sys_rst)
      (word_valid && width == `STX_W16) |-> (word_data[7:0] == 8'h00))
      else $error("16 bit word has low bits set");
   chk_lsb_w18: assert property (@(posedge core_clk) disable iff (sys_rst)
      (word_valid && width == `STX_W18) |-> (word_data[5:0] == 6'h00))
      else $error("18 bit word has low bits set");
   chk_lsb_w20: assert property (@(posedge core_clk) disable iff (sys_rst)
      (word_valid && width == `STX_W20) |-> (word_data[3:0] == 4'h0))
      else $error("20 bit word has low bits set");

   // Shifter and sync tracking
   chk_got_range: assert property (@(posedge core_clk) disable iff (sys_rst)
      capturing |-> (got < nbits))
      else $error("bit count past word length");
   chk_cap_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      (rise && capturing && last_bit && !start_bit) |=> !capturing)
      else $error("capture runs past last bit");
   chk_fs_track: assert property (@(posedge core_clk) disable iff (sys_rst)
      rise |=> (fs_prev == $past(fs_now)))
      else $error("frame sync not taken on rising edge");

   // Output stream and overflow
   chk_out_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      (word_valid && !word_ready) |=> (word_valid && $stable(word_data) && $stable(word_right)))
      else $error("output word changed while stalled");
   chk_out_load: assert property (@(posedge core_clk) disable iff (sys_rst)
      (ff_out_valid && pop_ok) |=> word_valid)
      else $error("queued word not presented");
   chk_ovf_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
      overflow |=> overflow)
      else $error("overflow flag cleared without reset");
   chk_ovf_set: assert property (@(posedge core_clk) disable iff (sys_rst)
      (wr_valid && !ff_in_ready) |-> ##2 overflow)
      else $error("lost word did not raise overflow");
endmodule

// *** tb/stx_serial_in_tb.sv ***
/*
 Self-checking bench for the serial audio input stage.
 Assumes the source model drives the pins and words leave by valid/ready.
*/
module stx_serial_in_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import stx_pkg::*;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic sclk;
   logic fsync;
   logic sdata;
   stx_fmt_e fmt = STX_FMT_I2S;
   stx_width_t width = 2'h0;
   logic word_ready = 1'b1;
   logic word_valid;
   logic word_right;
   logic overflow;
   logic [23:0] word_data;
   logic [24:0] got_q[$];
   logic [24:0] exp_q[$];
   int err_count = 0;
   int n_tests = 0;

   // 50 MHz core clock
   always #10 core_clk = ~core_clk;

   stx_serial_in stx_serial_in_i (.core_clk(core_clk), .sys_rst(sys_rst), .sclk(sclk), .fsync(fsync),
      .sdata(sdata), .fmt(fmt), .width(width), .word_valid(word_valid), .word_ready(word_ready),
      .word_data(word_data), .word_right(word_right), .overflow(overflow));
   stx_src_model stx_src_model_i (.sclk(sclk), .fsync(fsync), .sdata(sdata));

   // Collect every word taken on the output stream
   always @(posedge core_clk) begin
      if (word_valid === 1'b1 && word_ready === 1'b1) begin
         got_q.push_back({word_right, word_data});
      end
   end

   task automatic chk(input logic [24:0] exp, input logic [24:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t exp %h got %h", $time, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Send a frame and queue its two words, left aligned to bit 23
   task automatic frame(input int nb, input logic [23:0] l, input logic [23:0] r);
      logic [23:0] m;
      m = (24'h1 << nb) - 24'h1;
      stx_src_model_i.send_frame(fmt, nb, l & m, r & m);
      exp_q.push_back({1'b0, 24'((l & m) << (24 - nb))});
      exp_q.push_back({1'b1, 24'((r & m) << (24 - nb))});
   endtask

   // Wait for n words, bounded, then compare in order
   task automatic drain(input int n);
      for (int i = 0; i < 3000 && got_q.size() < n; i++) @(posedge core_clk);
      @(negedge core_clk); // Let the last take settle
      chk(25'(n), 25'(got_q.size()));
      while (got_q.size() > 0 && exp_q.size() > 0) chk(exp_q.pop_front(), got_q.pop_front());
      got_q.delete();
      exp_q.delete();
   endtask

   // Every framing and width, words taken at once
   task automatic t_formats();
      for (int f = 0; f < 3; f++) begin
         for (int w = 0; w < 4; w++) begin
            @(negedge core_clk);
            fmt = stx_fmt_e'(f);
            width = stx_width_t'(w);
            frame((w == 3) ? 24 : 16 + 2 * w, 24'hC5A3E1 ^ 24'(f * 4 + w), 24'h9B3D87 + 24'(w));
            drain(2);
         end
      end
      $display("t_formats done");
   endtask

   // FIFO and output register hold 33 words while the encoder stalls; the 34th is lost
   task automatic t_overflow();
      @(negedge core_clk);
      fmt = STX_FMT_I2S;
      width = 2'h0;
      word_ready = 1'b0;
      for (int i = 0; i < 17; i++) frame(16, 24'(16'h8001 + i), 24'(16'h7FFE - i));
      void'(exp_q.pop_back());
      for (int i = 0; i < 20 && overflow !== 1'b1; i++) @(posedge core_clk);
      chk(25'h1, {24'h0, overflow});
      @(negedge core_clk);
      word_ready = 1'b1;
      drain(33);
      chk(25'h0, {24'h0, word_valid});
      @(negedge core_clk);
      sys_rst = 1'b1;
      @(negedge core_clk);
      sys_rst = 1'b0;
      chk(25'h0, {24'h0, overflow});
      $display("t_overflow done");
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      sys_rst = 1'b0;
      t_formats();
      t_overflow();
      end_of_test();
   end

   // Watchdog, about three times the expected run
   initial begin
      #1000000;
      err_count++;
      $display("[ERR] %0t watchdog exp %h got %h", $time, 1'b0, 1'b1);
      end_of_test();
   end
endmodule

// *** tb/stx_src_model.sv ***
/*
 Serial audio source model: bit clock, frame sync and data pins.
 Assumes the bench calls send_frame with the sink set to the same framing.
*/
module stx_src_model (
   output logic sclk, // Bit clock, still between frames
   output logic fsync, // Frame sync
   output logic sdata // Serial data, toggles outside words
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle pins
   initial begin
      sclk = 1'b0;
      fsync = 1'b0;
      sdata = 1'b0;
   end
   // One slot of n bit clocks; pins change on the falling edge
   task automatic slot(input logic lvl, input int d, input int nb, input logic [23:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         sclk = 1'b0;
         fsync = lvl;
         sdata = (i >= d && i < d + nb) ? w[nb-1-(i-d)] : ~sdata;
         #80 sclk = 1'b1;
         #80;
      end
      sclk = 1'b0;
      sdata = ~sdata;
   endtask
   // Lead-in clock in the right slot, then left and right slots of 32 clocks
   task automatic send_frame(input logic [1:0] f, input int nb, input logic [23:0] l, input logic [23:0] r);
      logic left_lvl;
      int d;
      left_lvl = (f != 2'h0);
      d = (f == 2'h0) ? 1 : (f == 2'h1) ? 0 : 32 - nb;
      slot(~left_lvl, 32, 0, 24'h0, 1);
      slot(left_lvl, d, nb, l, 32);
      slot(~left_lvl, d, nb, r, 32);
   endtask
endmodule
